/* File: hdl/phase_sync_cfg.svh */
// offsets, field positions, reset values and timing figures of the config block
`ifndef PHASE_SYNC_CFG_SVH
`define PHASE_SYNC_CFG_SVH
`define SCC_OFF 8'h00
`define PH_LO_OFF 8'h04
`define PH_HI_OFF 8'h08
`define ADDR1_OFF 8'h0c
`define ADDR2_OFF 8'h10
`define DTC_OFF 8'h14
`define TMR_OFF 8'h18
`define PERIOD_OFF 8'h1c
`define STATUS_OFF 8'h20
`define SCC_RST 8'h40
`define PERIOD_RST 8'h27
`define SCC_CLAMP_SRC 7
`define SCC_PEDESTAL 6
`define SCC_LDO_KEEP 5
`define SCC_CURRENT 4
`define SCC_CLAMP_EN 3
`define DTC_DRIVE_EN 0
`define OSC_FREQ_KHZ 8000
`define PCLK_FREQ_KHZ 20000
`define OSC_ACC_STEP (2 * `OSC_FREQ_KHZ)
`endif

/* File: hdl/phase_sync_pkg.sv */
// types and role decoding shared by the config block
`default_nettype none
package phase_sync_pkg;
	typedef enum logic [6:0] {
		ROLE_STANDALONE = 7'b0000001,
		ROLE_MO_MASTER = 7'b0000010,
		ROLE_MO_SLAVE_CLK = 7'b0000100,
		ROLE_MP_MASTER = 7'b0001000,
		ROLE_MP_SLAVE = 7'b0010000,
		ROLE_MO_SLAVE_SYNC = 7'b0100000,
		ROLE_UNDEFINED = 7'b1000000
	} role_type;

	// three-bit select field to role
	function automatic role_type decode_role(input logic [2:0] sel);
		role_type r;
		r = ROLE_UNDEFINED;
		case (sel)
			3'h0: r = ROLE_STANDALONE;
			3'h1: r = ROLE_MO_MASTER;
			3'h2: r = ROLE_MO_SLAVE_CLK;
			3'h3: r = ROLE_MP_MASTER;
			3'h4: r = ROLE_MP_SLAVE;
			3'h5: r = ROLE_MO_MASTER;
			3'h6: r = ROLE_MO_SLAVE_SYNC;
			default: r = ROLE_UNDEFINED;
		endcase
		return r;
	endfunction : decode_role
endpackage : phase_sync_pkg
`default_nettype wire

/* File: hdl/phase_offset_delay.sv */
// delays a received sync edge until the timebase tick after the programmed number of ticks has counted down
`default_nettype none
module phase_offset_delay #(
	parameter int W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic tick,
	input wire logic [W-1:0] offset,
	output logic fire
);
	typedef struct packed {
		logic busy;
		logic [W-1:0] cnt;
		logic fire;
	} dly_state_type;

	dly_state_type st_q;
	dly_state_type st_d;

	// a new sync edge restarts the count, so a late edge never doubles a pulse
	always_comb
	begin
		st_d = st_q;
		st_d.fire = 1'b0;
		if (start)
		begin
			st_d.busy = 1'b1;
			st_d.cnt = offset;
		end
		else if (st_q.busy && tick)
		begin
			if (st_q.cnt == '0)
			begin
				st_d.busy = 1'b0;
				st_d.fire = 1'b1;
			end
			else
				st_d.cnt = st_q.cnt - W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign fire = st_q.fire;

	chk_fire_needs_busy: assert property (@(posedge pclk) disable iff (!presetn)
		st_q.fire |-> $past(st_q.busy) && !st_q.busy)
		else $error("delay fired while idle");
endmodule : phase_offset_delay
`default_nettype wire

/* File: hdl/phase_sync_config_control.sv */
// system configuration register, pin roles and switching timebase over APB
`default_nettype none
`include "phase_sync_cfg.svh"
module phase_sync_config_control #(
	parameter int CS_W = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sync_pin_in,
	output logic sync_pin_out,
	output logic sync_pin_oe,
	input wire logic system_clock_pin_in,
	output logic system_clock_pin_out,
	output logic system_clock_pin_oe,
	input wire logic [CS_W-1:0] current_share_pin_in,
	output logic [CS_W-1:0] current_share_pin_out,
	output logic current_share_pin_oe,
	input wire logic [CS_W-1:0] current_sense_sample,
	input wire logic over_temp_in,
	output logic [CS_W-1:0] regulation_sense,
	output logic regulate_current,
	output logic pedestal_enable,
	output logic clamp_enable,
	output logic clamp_source_select,
	output logic ldo_keep_on_in_sleep,
	output logic gate_drive_enable,
	output phase_sync_pkg::role_type role
);
	import phase_sync_pkg::*;

	typedef struct packed {
		logic [7:0] scc;
		logic [7:0] ph_lo;
		logic [7:0] ph_hi;
		logic [6:0] addr1;
		logic [6:0] addr2;
		logic [7:0] dtc;
		logic [7:0] tmr;
		logic [7:0] period;
		logic rdy;
		logic slverr;
		logic [31:0] rdata;
		logic sync_s1;
		logic sync_s2;
		logic sync_s3;
		logic clk_s1;
		logic clk_s2;
		logic clk_s3;
		logic ot_s1;
		logic ot_s2;
		logic [CS_W-1:0] cs_s1;
		logic [CS_W-1:0] cs_s2;
		logic [15:0] acc;
		logic osc;
		logic sync_out;
		logic sync_oe;
		logic clk_oe;
		logic clk_out;
		logic cs_oe;
		logic [CS_W-1:0] cs_out;
		logic [CS_W-1:0] reg_sense;
		logic gate_en;
		role_type role;
	} state_type;

	state_type st_q;
	state_type st_d;
	logic tick;
	logic ext_clk;
	logic sync_edge;
	logic fire;
	logic setup;
	logic wr_take;

	// apb phases; the answer always comes in the first access cycle
	assign setup = psel && !penable;
	assign wr_take = psel && penable && st_q.rdy && pwrite;

	// slaves with a clock pin count master clock edges, others the own oscillator
	assign ext_clk = (st_q.role == ROLE_MO_SLAVE_CLK) || (st_q.role == ROLE_MP_SLAVE);
	// internal tick is the coming osc rise, read from state only so no loop forms
	assign tick = ext_clk ? (st_q.clk_s2 && !st_q.clk_s3)
		: (!st_q.osc && (st_q.acc + 16'(`OSC_ACC_STEP) >= 16'(`PCLK_FREQ_KHZ)));
	assign sync_edge = st_q.sync_s2 && !st_q.sync_s3;

	// received sync edge waits out the programmed offset before restarting the timer
	phase_offset_delay #(
		.W(16)
	) u_delay (
		.pclk(pclk),
		.presetn(presetn),
		.start(sync_edge && (st_q.role == ROLE_MO_SLAVE_CLK
			|| st_q.role == ROLE_MP_SLAVE || st_q.role == ROLE_MO_SLAVE_SYNC)),
		.tick(tick),
		.offset({st_q.ph_hi, st_q.ph_lo}),
		.fire(fire)
	);

	always_comb
	begin
		st_d = st_q;
		// pin inputs cross in through two flops before any use
		st_d.sync_s1 = sync_pin_in;
		st_d.sync_s2 = st_q.sync_s1;
		st_d.sync_s3 = st_q.sync_s2;
		st_d.clk_s1 = system_clock_pin_in;
		st_d.clk_s2 = st_q.clk_s1;
		st_d.clk_s3 = st_q.clk_s2;
		st_d.ot_s1 = over_temp_in;
		st_d.ot_s2 = st_q.ot_s1;
		st_d.cs_s1 = current_share_pin_in;
		st_d.cs_s2 = st_q.cs_s1;

		// 8 MHz from 20 MHz by phase accumulation; average exact, edges jitter
		if (st_q.acc + 16'(`OSC_ACC_STEP) >= 16'(`PCLK_FREQ_KHZ))
		begin
			st_d.acc = st_q.acc + 16'(`OSC_ACC_STEP) - 16'(`PCLK_FREQ_KHZ);
			st_d.osc = !st_q.osc;
		end
		else
			st_d.acc = st_q.acc + 16'(`OSC_ACC_STEP);

		// switching timebase; a delayed master edge realigns a slave
		if (fire)
			st_d.tmr = 8'h00;
		else if (tick)
			st_d.tmr = (st_q.tmr >= st_q.period) ? 8'h00 : st_q.tmr + 8'h01;

		// role and pin directions follow the select field
		st_d.role = decode_role(st_q.scc[2:0]);
		st_d.sync_oe = (st_q.role == ROLE_MO_MASTER) || (st_q.role == ROLE_MP_MASTER);
		st_d.clk_oe = (st_q.role == ROLE_MP_MASTER)
			|| (st_q.role == ROLE_MO_MASTER && st_q.scc[2:0] == 3'h1);
		st_d.clk_out = st_d.osc && st_d.clk_oe;
		st_d.cs_oe = (st_q.role == ROLE_MP_MASTER);
		st_d.sync_out = st_d.sync_oe && (st_q.tmr < {1'b0, st_q.period[7:1]});
		st_d.cs_out = current_sense_sample;
		st_d.reg_sense = (st_q.role == ROLE_MP_SLAVE) ? st_q.cs_s2 : current_sense_sample;

		// thermal trip overrides software; drive drops one cycle after the synchronised trip is seen
		st_d.gate_en = st_q.dtc[`DTC_DRIVE_EN] && !st_q.ot_s2
			&& (st_q.role != ROLE_UNDEFINED);

		// read data and error are prepared in the setup cycle
		st_d.rdy = setup;
		st_d.slverr = 1'b0;
		if (setup)
		begin
			st_d.rdata = 32'h0000_0000;
			if (paddr == `SCC_OFF)
				st_d.rdata = {24'h000000, st_q.scc};
			else if (paddr == `PH_LO_OFF)
				st_d.rdata = {24'h000000, st_q.ph_lo};
			else if (paddr == `PH_HI_OFF)
				st_d.rdata = {24'h000000, st_q.ph_hi};
			else if (paddr == `ADDR1_OFF)
				st_d.rdata = {25'h0, st_q.addr1};
			else if (paddr == `ADDR2_OFF)
				st_d.rdata = {25'h0, st_q.addr2};
			else if (paddr == `DTC_OFF)
				st_d.rdata = {24'h000000, st_q.dtc};
			else if (paddr == `TMR_OFF)
				st_d.rdata = {24'h000000, st_q.tmr};
			else if (paddr == `PERIOD_OFF)
				st_d.rdata = {24'h000000, st_q.period};
			else if (paddr == `STATUS_OFF)
				st_d.rdata = {22'h0, st_q.ot_s2, st_q.gate_en, ext_clk, 7'(st_q.role)};
			else
				st_d.slverr = 1'b1;
		end
		else
			st_d.rdata = st_q.rdata;

		// writes land on the access edge; timer write beats its own count
		if (wr_take)
		begin
			if (paddr == `SCC_OFF)
				st_d.scc = pwdata[7:0];
			else if (paddr == `PH_LO_OFF)
				st_d.ph_lo = pwdata[7:0];
			else if (paddr == `PH_HI_OFF)
				st_d.ph_hi = pwdata[7:0];
			else if (paddr == `ADDR1_OFF)
				st_d.addr1 = pwdata[6:0];
			else if (paddr == `ADDR2_OFF)
				st_d.addr2 = pwdata[6:0];
			else if (paddr == `DTC_OFF)
				st_d.dtc = pwdata[7:0];
			else if (paddr == `TMR_OFF)
				st_d.tmr = pwdata[7:0];
			else if (paddr == `PERIOD_OFF)
				st_d.period = pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q <= '0;
			st_q.scc <= `SCC_RST;
			st_q.period <= `PERIOD_RST;
			st_q.role <= ROLE_STANDALONE;
		end
		else
			st_q <= st_d;
	end

	// every output is a field of the state register
	assign prdata = st_q.rdata;
	assign pready = st_q.rdy;
	assign pslverr = st_q.slverr;
	assign sync_pin_out = st_q.sync_out;
	assign sync_pin_oe = st_q.sync_oe;
	assign system_clock_pin_out = st_q.clk_out;
	assign system_clock_pin_oe = st_q.clk_oe;
	assign current_share_pin_out = st_q.cs_out;
	assign current_share_pin_oe = st_q.cs_oe;
	assign regulation_sense = st_q.reg_sense;
	assign regulate_current = st_q.scc[`SCC_CURRENT];
	assign pedestal_enable = st_q.scc[`SCC_PEDESTAL];
	assign clamp_enable = st_q.scc[`SCC_CLAMP_EN];
	assign clamp_source_select = st_q.scc[`SCC_CLAMP_SRC];
	assign ldo_keep_on_in_sleep = st_q.scc[`SCC_LDO_KEEP];
	assign gate_drive_enable = st_q.gate_en;
	assign role = st_q.role;

	chk_reset_value: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> st_q.scc == `SCC_RST)
		else $error("config register reset value wrong");

	chk_pedestal_hold: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> pedestal_enable)
		else $error("pedestal not enabled after reset");

	chk_role_decode: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> role == decode_role($past(st_q.scc[2:0])))
		else $error("role does not follow select field");

	chk_sync_master_out: assert property (@(posedge pclk) disable iff (!presetn)
		(role == ROLE_MP_MASTER) [*2] |-> sync_pin_oe && current_share_pin_oe)
		else $error("multi-phase master not driving sync and share");

	chk_clock_master_out: assert property (@(posedge pclk) disable iff (!presetn)
		(st_q.scc[2:0] == 3'h3) [*3] |-> system_clock_pin_oe)
		else $error("master not driving clock pin");

	chk_share_value: assert property (@(posedge pclk) disable iff (!presetn)
		current_share_pin_oe |-> current_share_pin_out == $past(current_sense_sample))
		else $error("share pin not carrying own sample");

	chk_slave_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
		(role == ROLE_MP_SLAVE) [*2] |-> !sync_pin_oe && !system_clock_pin_oe
			&& !current_share_pin_oe)
		else $error("slave drives a pin");

	chk_slave_ext_tick: assert property (@(posedge pclk) disable iff (!presetn)
		(role == ROLE_MP_SLAVE) |-> tick == (st_q.clk_s2 && !st_q.clk_s3))
		else $error("slave not ticking on master clock");

	chk_slave_sense: assert property (@(posedge pclk) disable iff (!presetn)
		(role == ROLE_MP_SLAVE) |=> regulation_sense == $past(st_q.cs_s2))
		else $error("slave not regulating to received share");

	chk_phase_realign: assert property (@(posedge pclk) disable iff (!presetn)
		fire && !wr_take |=> st_q.tmr == 8'h00)
		else $error("timer not restarted after phase delay");

	chk_thermal_off: assert property (@(posedge pclk) disable iff (!presetn)
		st_q.ot_s2 |=> !gate_drive_enable)
		else $error("drivers on during over-temperature");

	chk_drive_enable: assert property (@(posedge pclk) disable iff (!presetn)
		st_q.dtc[0] && !st_q.ot_s2 && role != ROLE_UNDEFINED |=> gate_drive_enable)
		else $error("drive enable bit ignored");

	chk_current_mode: assert property (@(posedge pclk) disable iff (!presetn)
		wr_take && paddr == `SCC_OFF |=> regulate_current == $past(pwdata[4]))
		else $error("current select not applied");

	chk_sync_needs_oe: assert property (@(posedge pclk) disable iff (!presetn)
		!sync_pin_oe |-> !sync_pin_out)
		else $error("sync level shown while not driving");

	chk_clock_needs_oe: assert property (@(posedge pclk) disable iff (!presetn)
		!system_clock_pin_oe |-> !system_clock_pin_out)
		else $error("clock level shown while not driving");

	chk_share_oe_master: assert property (@(posedge pclk) disable iff (!presetn)
		current_share_pin_oe |-> $past(role == ROLE_MP_MASTER))
		else $error("share pin driven outside master role");

	chk_mo_slave_inputs: assert property (@(posedge pclk) disable iff (!presetn)
		(role == ROLE_MO_SLAVE_CLK) [*2] |-> !sync_pin_oe && !system_clock_pin_oe)
		else $error("clocked output slave drives a pin");

	chk_sync_only_slave: assert property (@(posedge pclk) disable iff (!presetn)
		(role == ROLE_MO_SLAVE_SYNC) [*2] |-> !sync_pin_oe && !system_clock_pin_oe)
		else $error("sync-only slave drives a pin");

	chk_undefined_off: assert property (@(posedge pclk) disable iff (!presetn)
		role == ROLE_UNDEFINED |=> !gate_drive_enable)
		else $error("drivers on in undefined role");

	chk_pedestal_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_take && paddr == `SCC_OFF |=> pedestal_enable == $past(pwdata[`SCC_PEDESTAL]))
		else $error("pedestal bit not applied");

	chk_alert_addr_load: assert property (@(posedge pclk) disable iff (!presetn)
		wr_take && paddr == `ADDR2_OFF |=> st_q.addr2 == $past(pwdata[6:0]))
		else $error("alert address not stored");

	chk_phase_low_load: assert property (@(posedge pclk) disable iff (!presetn)
		wr_take && paddr == `PH_LO_OFF |=> st_q.ph_lo == $past(pwdata[7:0]))
		else $error("phase low not stored");

	chk_current_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr_take && paddr == `SCC_OFF) |=> $stable(regulate_current))
		else $error("current select changed without a write");
endmodule : phase_sync_config_control
`default_nettype wire

/* File: test/peer_converter.sv */
// peer converter acting as the multi-phase master on the far side of the pins
`default_nettype none
module peer_converter (
	input wire logic run,
	input wire logic [9:0] share_val,
	output logic clk_pin,
	output logic sync_pin,
	output logic [9:0] share_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	int n;
	// 400 ns link clock, phase unrelated to pclk; low from start, holds its level while not running
	initial
	begin
		clk_pin = 1'b0;
		sync_pin = 1'b0;
		n = 0;
		#7;
		forever
		begin
			#200;
			if (run)
			begin
				clk_pin = ~clk_pin;
				n = n + 1;
				if (n % 40 == 0)
					sync_pin = ~sync_pin;
			end
		end
	end
	// released bus shows the inverse so a stale value cannot pass
	assign share_pin = run ? share_val : ~share_val;
endmodule : peer_converter
`default_nettype wire

/* File: test/test_phase_sync_config_control.sv */
// self-checking bench for the configuration register and pin roles
`default_nettype none
`include "phase_sync_cfg.svh"
module test_phase_sync_config_control;
	timeunit 1ns;
	timeprecision 1ns;
	import phase_sync_pkg::*;
	logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, v, seed = 32'h9e5e;
	logic pready, pslverr, err, sync_in, clk_in, run = 1'b0, over_temp = 1'b0;
	logic [9:0] share_val = 10'h0, sense = 10'h0, share_in, share_out, reg_sense;
	logic sync_out, sync_oe, clk_out, clk_oe, share_oe, reg_cur, ped, gate, ps, pc;
	logic clamp_en, clamp_src, ldo_keep;
	role_type role;
	int err_count = 0, tests_run = 0, cycles = 0, n1, n2;

	phase_sync_config_control #(.CS_W(10)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_pin_in(sync_in),
		.sync_pin_out(sync_out), .sync_pin_oe(sync_oe), .system_clock_pin_in(clk_in),
		.system_clock_pin_out(clk_out), .system_clock_pin_oe(clk_oe),
		.current_share_pin_in(share_in), .current_share_pin_out(share_out),
		.current_share_pin_oe(share_oe), .current_sense_sample(sense),
		.over_temp_in(over_temp), .regulation_sense(reg_sense), .regulate_current(reg_cur),
		.pedestal_enable(ped), .clamp_enable(clamp_en), .clamp_source_select(clamp_src),
		.ldo_keep_on_in_sleep(ldo_keep), .gate_drive_enable(gate), .role(role));

	peer_converter peer (.run(run), .share_val(share_val), .clk_pin(clk_in),
		.sync_pin(sync_in), .share_pin(share_in));

	// 20 MHz clock
	initial
	begin
		pclk = 1'b0;
		forever
			#25 pclk = ~pclk;
	end

	// hang guard
	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			err_count++;
			summarize();
		end
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	function automatic role_type exp_role(input logic [2:0] c);
		case (c)
			3'h0: return ROLE_STANDALONE;
			3'h1, 3'h5: return ROLE_MO_MASTER;
			3'h2: return ROLE_MO_SLAVE_CLK;
			3'h3: return ROLE_MP_MASTER;
			3'h4: return ROLE_MP_SLAVE;
			3'h6: return ROLE_MO_SLAVE_SYNC;
			default: return ROLE_UNDEFINED;
		endcase
	endfunction : exp_role

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle count assumed; only the hang guard ends this wait
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize

	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check("pedestal reset", 1, ped);
		check("role reset", 32'(ROLE_STANDALONE), 32'(role));
		apb(1'b0, `SCC_OFF, 0);
		check("config reset", 32'h40, rd);
		$display("reset test done");
		run <= 1'b1;
		// every select code with random upper bits and random sense values
		for (int c = 0; c < 8; c++)
		begin
			v = (rnd() & 32'hf8) | 32'(c);
			share_val <= 10'(rnd());
			sense <= 10'(rnd());
			apb(1'b1, `SCC_OFF, v);
			repeat (6) @(posedge pclk);
			check("role", 32'(exp_role(3'(c))), 32'(role));
			check("sync oe", c == 1 || c == 3 || c == 5, sync_oe);
			check("clock oe", c == 1 || c == 3, clk_oe);
			check("share oe", c == 3, share_oe);
			check("current", v[4], reg_cur);
			check("pedestal", v[6], ped);
			check("clamp enable", v[`SCC_CLAMP_EN], clamp_en);
			check("clamp source", v[`SCC_CLAMP_SRC], clamp_src);
			check("ldo keep on", v[`SCC_LDO_KEEP], ldo_keep);
			if (c == 3)
				check("share out", 32'(sense), 32'(share_out));
			check("reg sense", 32'(c == 4 ? share_in : sense), 32'(reg_sense));
			apb(1'b0, `SCC_OFF, 0);
			check("config read", v & 32'hff, rd);
		end
		$display("role test done");
		apb(1'b1, `TMR_OFF, 0);
		apb(1'b1, `SCC_OFF, 32'h14);
		repeat (4) @(posedge pclk);
		check("slave current", 1, reg_cur);
		// offset 2: timer restarts on the third master clock rise after a sync rise,
		// which falls 23 cycles after the pin edge, well before the next rise
		apb(1'b1, `PH_LO_OFF, 2);
		apb(1'b1, `PH_HI_OFF, 0);
		@(posedge sync_in);
		repeat (25) @(posedge pclk);
		apb(1'b0, `TMR_OFF, 0);
		check("slave timer", 0, rd);
		apb(1'b0, `STATUS_OFF, 0);
		check("slave status", 32'h90, rd);
		$display("slave phase test done");
		// multi-phase master: count pin toggles over 300 cycles
		apb(1'b1, `SCC_OFF, 32'h03);
		n1 = 0;
		n2 = 0;
		ps = sync_out;
		pc = clk_out;
		repeat (300)
		begin
			@(posedge pclk);
			n1 += int'(sync_out !== ps);
			n2 += int'(clk_out !== pc);
			ps = sync_out;
			pc = clk_out;
		end
		check("sync toggles", 1, n1 >= 4 && n1 <= 8);
		check("clock toggles", 1, n2 >= 230 && n2 <= 250);
		$display("master pin test done");
		for (int i = 0; i < 4; i++)
		begin
			v = rnd();
			apb(1'b1, 8'(4 + 4 * i), v);
			apb(1'b0, 8'(4 + 4 * i), 0);
			check("reg readback", v & (i < 2 ? 32'hff : 32'h7f), rd);
		end
		apb(1'b1, `SCC_OFF, 0);
		apb(1'b1, `DTC_OFF, 1);
		repeat (3) @(posedge pclk);
		check("gate on", 1, gate);
		over_temp <= 1'b1;
		repeat (5) @(posedge pclk);
		check("gate hot", 0, gate);
		over_temp <= 1'b0;
		apb(1'b0, 8'h24, 0);
		check("unmapped err", 1, err);
		check("unmapped data", 0, rd);
		$display("register test done");
		summarize();
	end
endmodule : test_phase_sync_config_control
`default_nettype wire
